//--- inc/tri_consts.svh
// Register offsets, field positions and reset values of the timer readout and flag block
`ifndef TRI_CONSTS_SVH
`define TRI_CONSTS_SVH
// Printed offsets are not all multiples of four: they are indices, byte address is index*4
`define TRI_IDX_T0_LO 16'hFFC8
`define TRI_IDX_T0_HI 16'hFFC9
`define TRI_IDX_T1_LO 16'hFFCA
`define TRI_IDX_T1_HI 16'hFFCB
`define TRI_IDX_MSK_TMR 16'hFFE2
`define TRI_IDX_MSK_SER 16'hFFE3
`define TRI_IDX_MSK_KG0 16'hFFE4
`define TRI_IDX_MSK_KG1 16'hFFE5
`define TRI_IDX_MSK_CLK 16'hFFE6
`define TRI_IDX_MSK_SW 16'hFFE7
`define TRI_IDX_FLG_TMR 16'hFFF2
`define TRI_IDX_FLG_SER 16'hFFF3
`define TRI_IDX_FLG_KG0 16'hFFF4
`define TRI_IDX_FLG_KG1 16'hFFF5
`define TRI_IDX_FLG_CLK 16'hFFF6
`define TRI_IDX_FLG_SW 16'hFFF7
`define TRI_NSRC 11
// Source positions in the packed source vector
`define TRI_SRC_T0 0
`define TRI_SRC_T1 1
`define TRI_SRC_SER 2
`define TRI_SRC_KG0 3
`define TRI_SRC_KG1 4
`define TRI_SRC_CLK32 5
`define TRI_SRC_CLK1 8
`define TRI_SRC_SW10 9
`define TRI_SRC_SW1 10
`define TRI_RESET_NIB 4'h0
`endif

//--- inc/tri_pkg.sv
// Types for the timer readout and interrupt flag block
package tri_pkg;
	typedef struct packed {
		logic [7:0] timer1_count_value;
		logic [7:0] timer0_count_value;
	} tri_counts_t;
	// One bit per source, order matches the source positions
	typedef struct packed {
		logic stopwatch_1hz;
		logic stopwatch_10hz;
		logic clk1hz;
		logic clk2hz;
		logic clk8hz;
		logic clk32hz;
		logic key_group1;
		logic key_group0;
		logic serial;
		logic timer1;
		logic timer0;
	} tri_src_t;
endpackage

//--- rtl/tri_irq.sv
// Timer count readout, interrupt masks and factor flags behind an APB slave
`include "tri_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module tri_irq (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire tri_pkg::tri_counts_t timer_counts,
	input wire tri_pkg::tri_src_t src_events,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	logic [10:0] mask_reg;
	logic [10:0] flag_reg;
	logic [10:0] flag_next;
	logic [10:0] wr_mask;
	logic [10:0] wr_clear;
	logic [10:0] rd_mask;
	logic [10:0] rd_flag;
	logic [15:0] idx;
	logic word_ok;
	logic hit;
	logic wr_en;
	logic [3:0] nib;
	logic [3:0] rd_nib;
	logic [31:0] prdata_reg;

	// Upper address bits must be zero and word aligned, else the access errors
	assign idx = paddr[17:2];
	assign word_ok = (paddr[31:18] == 14'h0000) && (paddr[1:0] == 2'h0);
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite && pstrb[0];
	assign nib = pwdata[3:0];

	////////////////////////////////////////////////////////////////////////////////
	// Decode: map a nibble-wide register onto the flat source vector
	always_comb begin
		wr_mask = 11'h000;
		wr_clear = 11'h000;
		rd_nib = `TRI_RESET_NIB;
		hit = 1'b1;
		unique case (idx)
			`TRI_IDX_T0_LO: rd_nib = timer_counts.timer0_count_value[3:0];
			`TRI_IDX_T0_HI: rd_nib = timer_counts.timer0_count_value[7:4];
			`TRI_IDX_T1_LO: rd_nib = timer_counts.timer1_count_value[3:0];
			`TRI_IDX_T1_HI: rd_nib = timer_counts.timer1_count_value[7:4];
			`TRI_IDX_MSK_TMR: begin
				rd_nib = {2'h0, mask_reg[1:0]};
				wr_mask[1:0] = 2'h3;
			end
			`TRI_IDX_MSK_SER: begin
				rd_nib = {3'h0, mask_reg[`TRI_SRC_SER]};
				wr_mask[`TRI_SRC_SER] = 1'b1;
			end
			`TRI_IDX_MSK_KG0: begin
				rd_nib = {3'h0, mask_reg[`TRI_SRC_KG0]};
				wr_mask[`TRI_SRC_KG0] = 1'b1;
			end
			`TRI_IDX_MSK_KG1: begin
				rd_nib = {3'h0, mask_reg[`TRI_SRC_KG1]};
				wr_mask[`TRI_SRC_KG1] = 1'b1;
			end
			`TRI_IDX_MSK_CLK: begin
				rd_nib = mask_reg[`TRI_SRC_CLK1:`TRI_SRC_CLK32];
				wr_mask[`TRI_SRC_CLK1:`TRI_SRC_CLK32] = 4'hF;
			end
			`TRI_IDX_MSK_SW: begin
				rd_nib = {2'h0, mask_reg[`TRI_SRC_SW1:`TRI_SRC_SW10]};
				wr_mask[`TRI_SRC_SW1:`TRI_SRC_SW10] = 2'h3;
			end
			`TRI_IDX_FLG_TMR: begin
				rd_nib = {2'h0, flag_reg[1:0]};
				wr_clear[1:0] = nib[1:0];
			end
			`TRI_IDX_FLG_SER: begin
				rd_nib = {3'h0, flag_reg[`TRI_SRC_SER]};
				wr_clear[`TRI_SRC_SER] = nib[0];
			end
			`TRI_IDX_FLG_KG0: begin
				rd_nib = {3'h0, flag_reg[`TRI_SRC_KG0]};
				wr_clear[`TRI_SRC_KG0] = nib[0];
			end
			`TRI_IDX_FLG_KG1: begin
				rd_nib = {3'h0, flag_reg[`TRI_SRC_KG1]};
				wr_clear[`TRI_SRC_KG1] = nib[0];
			end
			`TRI_IDX_FLG_CLK: begin
				rd_nib = flag_reg[`TRI_SRC_CLK1:`TRI_SRC_CLK32];
				wr_clear[`TRI_SRC_CLK1:`TRI_SRC_CLK32] = nib;
			end
			`TRI_IDX_FLG_SW: begin
				rd_nib = {2'h0, flag_reg[`TRI_SRC_SW1:`TRI_SRC_SW10]};
				wr_clear[`TRI_SRC_SW1:`TRI_SRC_SW10] = nib[1:0];
			end
			default: hit = 1'b0;
		endcase
		if (!word_ok) begin
			hit = 1'b0;
			rd_nib = `TRI_RESET_NIB;
		end
	end

	assign pslverr = psel && penable && !hit;

	////////////////////////////////////////////////////////////////////////////////
	// Mask register: written lanes only, unused bits never stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_reg <= 11'h000;
		end else if (wr_en && hit) begin
			mask_reg <= (mask_reg & ~wr_mask) | (wr_mask & {nib[1:0], nib, nib[0], nib[0], nib[0], nib[1:0]});
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flags: set by hardware, cleared by write one; set wins on a collision
	always_comb begin
		flag_next = flag_reg;
		if (wr_en && hit) begin
			flag_next = flag_next & ~wr_clear;
		end
		flag_next = flag_next | src_events;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_reg <= 11'h000;
		end else begin
			flag_reg <= flag_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data registered at the setup cycle so it is stable in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_reg <= {28'h000_0000, rd_nib};
		end
	end
	assign prdata = prdata_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(flag_next & mask_reg);
		end
	end

endmodule

//--- tb/tri_irq_properties.sv
// Port checks for the flag block
module tri_irq_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire tri_pkg::tri_counts_t timer_counts,
	input wire tri_pkg::tri_src_t src_events,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wr;
	assign wr = psel && penable && pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_rd(logic [31:0] a);
		psel && penable && !pwrite && paddr == a;
	endsequence
	a_cnt0_low: assert property (s_rd(32'h3FF20)
		|-> prdata == {28'h0, $past(timer_counts.timer0_count_value[3:0])}) else $error("t0 low");
	a_cnt1_high: assert property (s_rd(32'h3FF2C)
		|-> prdata == {28'h0, $past(timer_counts.timer1_count_value[7:4])}) else $error("t1 high");
	a_tmask_bits: assert property (s_rd(32'h3FF88)
		|-> prdata[31:2] == 30'h0) else $error("mask bits");
	a_read_upper: assert property (psel && penable && !pwrite && !pslverr
		|-> prdata[31:4] == 28'h0) else $error("upper bits");
	a_irq_cause: assert property ($rose(irq)
		|-> $past(|src_events) || $past(wr) || $past(wr, 2)) else $error("irq rise");
	a_irq_clear: assert property ($fell(irq)
		|-> $past(wr) || $past(wr, 2)) else $error("irq fall");
	a_ro_noerr: assert property (psel && penable && paddr == 32'h3FF20
		|-> !pslverr) else $error("ro error");
	a_err_unmapped: assert property (psel && penable && paddr == 32'h0
		|-> pslverr) else $error("no error");
endmodule
bind tri_irq tri_irq_properties chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.prdata, .pslverr, .timer_counts, .src_events, .irq);

//--- tb/tri_cpu_model.sv
// Core side: counts interrupt requests
module tri_cpu_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic irq,
	output logic [7:0] req_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic irq_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_cnt <= 8'h0;
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq;
			if (irq && !irq_reg) req_cnt <= req_cnt + 8'h1;
		end
	end
endmodule

//--- tb/test_timer_readout_and_irq_flags.sv
// Bench for the flag block
`include "tri_consts.svh"
module test_timer_readout_and_irq_flags;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pready, pslverr, irq, err;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdat;
	logic [7:0] req_cnt;
	tri_pkg::tri_counts_t timer_counts = 16'h0;
	tri_pkg::tri_src_t src_events = 11'h0;
	int fails = 0, num_checks = 0, cyc = 0, i;
	// Source order: flag register low nibble and bit
	localparam logic [43:0] FREG = 44'h77666654322;
	localparam logic [43:0] FBIT = 44'h10321000010;
	logic [19:0] rows [10] = '{20'hFFE23, 20'hFFE31, 20'hFFE41, 20'hFFE51, 20'hFFE6F,
		20'hFFE73, 20'hFFC83, 20'hFFC9C, 20'hFFCA5, 20'hFFCBA};
	tri_irq dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
		.prdata, .pready, .pslverr, .timer_counts, .src_events, .irq);
	tri_cpu_model cpu_u (.pclk, .presetn, .irq, .req_cnt);
	initial forever #20 pclk = ~pclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [15:0] x, input logic [3:0] d,
		input logic [10:0] ev);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {14'h0, x, 2'h0};
		pwdata <= {28'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		src_events <= ev;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		src_events <= 11'h0;
	endtask
	task automatic pulse(input logic [10:0] v);
		@(posedge pclk);
		src_events <= v;
		@(posedge pclk);
		src_events <= 11'h0;
		repeat (2) @(posedge pclk);
	endtask
	// Hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			results();
		end
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 16; i++) begin
			apb(1'b0, 16'(i < 4 ? 32'hFFC8 + i : i < 10 ? 32'hFFDE + i : 32'hFFE8 + i), 4'h0, 11'h0);
			chk(rdat, 32'h0);
		end
		$display("reset done");
		timer_counts <= 16'hA5C3;
		foreach (rows[r]) begin
			apb(1'b1, rows[r][19:4], 4'hF, 11'h0);
			apb(1'b0, rows[r][19:4], 4'h0, 11'h0);
			chk(rdat, {28'h0, rows[r][3:0]});
		end
		$display("table done");
		// Masks are all open now, so every source reaches irq
		for (i = 0; i < 11; i++) begin
			pulse(11'h1 << i);
			chk(32'(irq), 32'h1);
			apb(1'b1, 16'hFFF0 + FREG[4*i+:4], 4'h0, 11'h0);
			apb(1'b0, 16'hFFF0 + FREG[4*i+:4], 4'h0, 11'h0);
			chk(rdat, 32'h1 << FBIT[4*i+:4]);
			apb(1'b1, 16'hFFF0 + FREG[4*i+:4], 4'h1 << FBIT[4*i+:4], 11'h0);
			repeat (2) @(posedge pclk);
			chk(32'(irq), 32'h0);
		end
		chk({24'h0, req_cnt}, 32'hB);
		$display("flags done");
		apb(1'b1, `TRI_IDX_MSK_TMR, 4'h0, 11'h0);
		pulse(11'h1);
		chk(32'(irq), 32'h0);
		apb(1'b1, `TRI_IDX_MSK_TMR, 4'h1, 11'h0);
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h1);
		// Clear write meets a new event at the same edge
		apb(1'b1, `TRI_IDX_FLG_TMR, 4'h1, 11'h1);
		apb(1'b0, `TRI_IDX_FLG_TMR, 4'h0, 11'h0);
		chk(rdat, 32'h1);
		$display("mask done");
		apb(1'b0, 16'h0, 4'h0, 11'h0);
		chk({31'h0, err}, 32'h1);
		chk(rdat, 32'h0);
		$display("error done");
		// Reset in mid-run drops a pending, enabled flag and its mask
		chk(32'(irq), 32'h1);
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		chk(32'(irq), 32'h0);
		apb(1'b0, `TRI_IDX_FLG_TMR, 4'h0, 11'h0);
		chk(rdat, 32'h0);
		apb(1'b0, `TRI_IDX_MSK_TMR, 4'h0, 11'h0);
		chk(rdat, 32'h0);
		$display("reset again done");
		results();
	end
endmodule
